//--- shared/wdt_pkg.sv
// Constants and carrier types for the windowed watchdog timer
package wdt_pkg;
  localparam int unsigned CLOCK_FREQ_HZ = 125_000_000;
  localparam int unsigned LOW_POWER_RC_OSC_FREQ_HZ = 32_000;
  localparam int unsigned OSC_TICK_CYCLES = CLOCK_FREQ_HZ / LOW_POWER_RC_OSC_FREQ_HZ;
  localparam int unsigned OSC_CNT_W = 12;
  localparam int unsigned PRE_W = 7;
  localparam int unsigned POST_W = 15;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned ELAPSED_W = 23;
  localparam logic [PRE_W-1:0] PRE_LAST_SHORT = 7'h1F;
  localparam logic [PRE_W-1:0] PRE_LAST_LONG = 7'h7F;
  localparam logic [4:0] PRE_SHIFT_SHORT = 5'h05;
  localparam logic [4:0] PRE_SHIFT_LONG = 5'h07;
  localparam logic [PRE_W-1:0] PRE_RESET = 7'h00;
  localparam logic [POST_W-1:0] POST_RESET = 15'h0000;

  typedef struct packed {
    logic always_on_config_bit;
    logic window_disable_bit;
    logic prescale_select_bit;
    logic [FIELD_W-1:0] postscale_ratio_field;
  } watchdog_config_t;

  typedef struct packed {
    logic device_reset;
    logic clock_switch_done;
    logic power_save_enter;
    logic power_save_exit;
    logic watchdog_clear_instr;
  } watchdog_events_t;

  typedef enum logic [0:0] {
    MODE_NORMAL = 1'b0,
    MODE_SAVE = 1'b1
  } power_mode_t;
endpackage : wdt_pkg

//--- rtl/low_power_rc_osc.sv
// Tick source standing in for the low-power RC oscillator
`timescale 1ns/1ps
`default_nettype none
module low_power_rc_osc #(
  parameter int unsigned TICK_CYCLES = wdt_pkg::OSC_TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic run_in,
  output logic tick_out
);
  localparam logic [wdt_pkg::OSC_CNT_W-1:0] LAST = wdt_pkg::OSC_CNT_W'(TICK_CYCLES - 1);
  logic [wdt_pkg::OSC_CNT_W-1:0] count;

  // Stopped oscillator holds its phase at zero
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count == LAST);
      count <= (count == LAST) ? '0 : count + 1'b1;
    end
  end
endmodule : low_power_rc_osc
`default_nettype wire

//--- rtl/windowed_watchdog_timer.sv
// Windowed watchdog timer with prescaler, postscaler and sticky time-out flag
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_timer #(
  parameter int unsigned OSC_TICK_CYCLES = wdt_pkg::OSC_TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire wdt_pkg::watchdog_config_t config_in,
  input wire wdt_pkg::watchdog_events_t events_in,
  input wire logic software_enable_set_in,
  input wire logic software_enable_clear_in,
  input wire logic timeout_flag_clear_in,
  output logic watchdog_reset_out,
  output logic wake_out,
  output logic timeout_sticky_flag_out,
  output logic software_enable_bit_out,
  output logic low_power_rc_osc_run_out,
  output logic window_open_out
);
  function automatic logic [wdt_pkg::POST_W-1:0] post_last_of(
    input logic [wdt_pkg::FIELD_W-1:0] field
  );
    logic [wdt_pkg::POST_W:0] ratio;
    ratio = (wdt_pkg::POST_W + 1)'(1) << field;
    return wdt_pkg::POST_W'(ratio - 1'b1);
  endfunction : post_last_of

  function automatic logic [4:0] pre_shift_of(input logic sel);
    return sel ? wdt_pkg::PRE_SHIFT_LONG : wdt_pkg::PRE_SHIFT_SHORT;
  endfunction : pre_shift_of

  logic [wdt_pkg::PRE_W-1:0] pre_count;
  logic [wdt_pkg::POST_W-1:0] post_count;
  wdt_pkg::power_mode_t mode;
  logic software_enable;
  logic timeout_flag;
  logic osc_tick;
  logic enable;
  logic restart;
  logic pre_last;
  logic post_last;
  logic timeout;
  logic early_clear;
  logic [wdt_pkg::ELAPSED_W-1:0] elapsed;
  logic [wdt_pkg::ELAPSED_W-1:0] period;
  logic [wdt_pkg::ELAPSED_W-1:0] window_start;
  logic [wdt_pkg::PRE_W-1:0] pre_last_value;

  assign enable = config_in.always_on_config_bit | software_enable;

  low_power_rc_osc #(
    .TICK_CYCLES(OSC_TICK_CYCLES)
  ) u_osc (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .run_in(enable),
    .tick_out(osc_tick)
  );

  assign pre_last_value = config_in.prescale_select_bit ? wdt_pkg::PRE_LAST_LONG
                                                        : wdt_pkg::PRE_LAST_SHORT;
  assign pre_last = (pre_count >= pre_last_value);
  assign post_last = (post_count >= post_last_of(config_in.postscale_ratio_field));
  assign timeout = enable && osc_tick && pre_last && post_last;

  // Elapsed and period in oscillator ticks
  assign elapsed = (wdt_pkg::ELAPSED_W'(post_count) << pre_shift_of(config_in.prescale_select_bit))
                   | wdt_pkg::ELAPSED_W'(pre_count);
  assign period = wdt_pkg::ELAPSED_W'(1) << (5'(config_in.postscale_ratio_field)
                  + pre_shift_of(config_in.prescale_select_bit));
  assign window_start = period - (period >> 2);
  assign early_clear = enable && events_in.watchdog_clear_instr
                       && !config_in.window_disable_bit && (elapsed < window_start);

  assign restart = events_in.device_reset || events_in.clock_switch_done
                   || events_in.power_save_enter || events_in.power_save_exit
                   || events_in.watchdog_clear_instr || timeout || !enable;

  // Prescaler and postscaler; a config change mid-count is caught by the >= compares
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_count <= wdt_pkg::PRE_RESET;
      post_count <= wdt_pkg::POST_RESET;
    end else if (restart) begin
      pre_count <= wdt_pkg::PRE_RESET;
      post_count <= wdt_pkg::POST_RESET;
    end else if (osc_tick) begin
      if (pre_last) begin
        pre_count <= wdt_pkg::PRE_RESET;
        post_count <= post_count + 1'b1;
      end else begin
        pre_count <= pre_count + 1'b1;
      end
    end
  end

  // Power-save tracking; exit wins if both arrive together
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mode <= wdt_pkg::MODE_NORMAL;
    end else begin
      case (mode)
        wdt_pkg::MODE_NORMAL: begin
          if (events_in.power_save_enter && !events_in.power_save_exit) begin
            mode <= wdt_pkg::MODE_SAVE;
          end
        end
        wdt_pkg::MODE_SAVE: begin
          if (events_in.power_save_exit || events_in.device_reset || timeout) begin
            mode <= wdt_pkg::MODE_NORMAL;
          end
        end
        default: mode <= wdt_pkg::MODE_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      software_enable <= 1'b0;
    end else if (events_in.device_reset) begin
      software_enable <= 1'b0;
    end else if (software_enable_set_in) begin
      software_enable <= 1'b1;
    end else if (software_enable_clear_in) begin
      software_enable <= 1'b0;
    end
  end

  // Set beats clear so a time-out in the clearing cycle is kept
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      timeout_flag <= 1'b0;
    end else if (timeout || early_clear) begin
      timeout_flag <= 1'b1;
    end else if (timeout_flag_clear_in) begin
      timeout_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      watchdog_reset_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      watchdog_reset_out <= (timeout && mode == wdt_pkg::MODE_NORMAL) || early_clear;
      wake_out <= timeout && mode == wdt_pkg::MODE_SAVE;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_power_rc_osc_run_out <= 1'b0;
      window_open_out <= 1'b0;
    end else begin
      low_power_rc_osc_run_out <= enable;
      window_open_out <= enable && (config_in.window_disable_bit || elapsed >= window_start);
    end
  end

  assign timeout_sticky_flag_out = timeout_flag;
  assign software_enable_bit_out = software_enable;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  AST_OSC_FORCED: assert property (enable |=> low_power_rc_osc_run_out)
    else $error("oscillator not running while watchdog enabled");
  AST_PRE_WRAP: assert property (osc_tick && pre_last && !restart |=> pre_count == 7'h00)
    else $error("prescaler did not wrap at its limit");
  AST_PRE_SHORT: assert property ($stable(config_in) && !config_in.prescale_select_bit
    && pre_count <= 7'h1F |=> pre_count <= 7'h1F)
    else $error("short prescaler exceeded 32 counts");
  AST_POST_STEP: assert property (osc_tick && pre_last && !restart
    |=> post_count == $past(post_count) + 15'h0001)
    else $error("postscaler did not step on prescaler wrap");
  AST_PERIOD: assert property (timeout |-> elapsed == period - 23'h00_0001)
    else $error("time-out not at end of full period");
  AST_RESTART: assert property (events_in.clock_switch_done || events_in.watchdog_clear_instr
    |=> pre_count == 7'h00 && post_count == 15'h0000)
    else $error("counters not restarted");
  AST_NORMAL_TIMEOUT: assert property (timeout && mode == wdt_pkg::MODE_NORMAL
    |=> watchdog_reset_out && timeout_sticky_flag_out && !wake_out)
    else $error("normal time-out did not reset device");
  // Mode is checked in the wake cycle; a new power-save entry may follow at once
  AST_SAVE_WAKE: assert property (timeout && mode == wdt_pkg::MODE_SAVE
    |=> wake_out && !watchdog_reset_out && mode == wdt_pkg::MODE_NORMAL)
    else $error("power-save time-out did not wake");
  AST_FLAG_STICKY: assert property (timeout_flag && !timeout_flag_clear_in |=> timeout_flag)
    else $error("sticky flag lost without software clear");
  AST_ALWAYS_ON: assert property (config_in.always_on_config_bit && software_enable_clear_in
    |=> low_power_rc_osc_run_out)
    else $error("software disabled an always-on watchdog");
  AST_SW_OFF: assert property (!config_in.always_on_config_bit && !software_enable
    |=> !low_power_rc_osc_run_out)
    else $error("watchdog on without software enable");
  AST_SW_RESET: assert property (events_in.device_reset |=> !software_enable_bit_out)
    else $error("device reset left software enable set");
  // Back-to-back early clears legally keep the reset high, so no drop is demanded
  AST_EARLY_CLEAR: assert property (early_clear
    |=> watchdog_reset_out && timeout_sticky_flag_out)
    else $error("early clear in window mode gave no reset");

  COV_TIMEOUT: cover property (timeout && mode == wdt_pkg::MODE_NORMAL);
  COV_WAKE: cover property (timeout && mode == wdt_pkg::MODE_SAVE);
  COV_EARLY: cover property (early_clear);
  COV_LATE_CLEAR: cover property (events_in.watchdog_clear_instr && window_open_out
    && !config_in.window_disable_bit);
endmodule : windowed_watchdog_timer
`default_nettype wire

//--- testbench/test_windowed_watchdog_timer.sv
// Self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module test_windowed_watchdog_timer;
  // Short oscillator tick keeps every period within a few thousand cycles
  localparam int unsigned TICK = 4;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  wdt_pkg::watchdog_config_t config_in = 7'h20;
  wdt_pkg::watchdog_events_t events_in = 5'h00;
  logic sw_set = 1'b0;
  logic sw_clr = 1'b0;
  logic flag_clr = 1'b0;
  logic wd_reset, wake, flag, sw_bit, osc_run, win_open;
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;

  windowed_watchdog_timer #(.OSC_TICK_CYCLES(TICK)) windowed_watchdog_timer_i (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .config_in(config_in),
    .events_in(events_in), .software_enable_set_in(sw_set),
    .software_enable_clear_in(sw_clr), .timeout_flag_clear_in(flag_clr),
    .watchdog_reset_out(wd_reset), .wake_out(wake), .timeout_sticky_flag_out(flag),
    .software_enable_bit_out(sw_bit), .low_power_rc_osc_run_out(osc_run),
    .window_open_out(win_open));

  always #4 clock_in = ~clock_in;

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  // Bound from the sum of all periods below, with ample margin
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      final_report();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask : check

  task step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : step

  task pulse_ev(input wdt_pkg::watchdog_events_t e);
    events_in = e;
    step(1);
    events_in = 5'h00;
  endtask : pulse_ev

  task enable_sw;
    sw_set = 1'b1;
    step(1);
    sw_set = 1'b0;
  endtask : enable_sw

  task disable_all;
    config_in = 7'h20;
    sw_clr = 1'b1;
    flag_clr = 1'b1;
    step(1);
    sw_clr = 1'b0;
    flag_clr = 1'b0;
    step(2);
  endtask : disable_all

  // Tolerance covers the tick phase and the registered output stage
  task wait_out(input int exp, input logic want_wake);
    int n;
    n = 0;
    while (!(wd_reset === 1'b1 || wake === 1'b1) && n < exp + 40) begin
      step(1);
      n++;
    end
    check(n >= exp - 8 && n <= exp + 8, 1);
    check(wake, want_wake);
    check(wd_reset, !want_wake);
  endtask : wait_out

  task t_reset;
    check({wd_reset, wake, flag, sw_bit, osc_run, win_open}, 6'h00);
    $display("test reset done");
  endtask : t_reset

  task t_periods;
    for (int f = 0; f < 4; f++) begin
      // Non-window, short prescale, so the expected period is 32 << f ticks
      config_in = {3'h2, 4'(f)};
      enable_sw();
      check(sw_bit, 1);
      step(1);
      check(osc_run, 1);
      wait_out((32 << f) * TICK - 2, 0);
      step(1);
      check({wd_reset, flag}, 2'h1);
      step(20);
      check(flag, 1);
      disable_all();
      check({flag, osc_run}, 2'h0);
    end
    config_in = 7'h31;
    enable_sw();
    wait_out(128 * 2 * TICK - 1, 0);
    disable_all();
    $display("test periods done");
  endtask : t_periods

  task t_always;
    config_in = 7'h60;
    sw_clr = 1'b1;
    step(1);
    sw_clr = 1'b0;
    step(2);
    check(osc_run, 1);
    wait_out(32 * TICK - 3, 0);
    disable_all();
    $display("test always on done");
  endtask : t_always

  task t_save;
    enable_sw();
    pulse_ev(5'h04);
    wait_out(32 * TICK - 1, 1);
    // Sleep and idle status bits sit outside this block; software clears them
    pulse_ev(5'h04);
    step(100);
    pulse_ev(5'h02);
    wait_out(32 * TICK - 1, 0);
    disable_all();
    $display("test power save done");
  endtask : t_save

  task t_restart;
    enable_sw();
    step(100);
    pulse_ev(5'h01);
    wait_out(32 * TICK - 1, 0);
    step(100);
    pulse_ev(5'h08);
    wait_out(32 * TICK - 1, 0);
    pulse_ev(5'h10);
    check({sw_bit, flag}, 2'h1);
    disable_all();
    $display("test restart done");
  endtask : t_restart

  task t_window;
    config_in = 7'h00;
    enable_sw();
    step(10);
    check(win_open, 0);
    pulse_ev(5'h01);
    wait_out(1, 0);
    step(1);
    check(flag, 1);
    step(104);
    check(win_open, 1);
    pulse_ev(5'h01);
    step(1);
    check(wd_reset, 0);
    wait_out(32 * TICK - 2, 0);
    disable_all();
    $display("test window done");
  endtask : t_window

  initial begin
    repeat (2) @(posedge clock_in);
    #1;
    arst_n_in = 1'b1;
    step(1);
    t_reset();
    t_periods();
    t_always();
    t_save();
    t_restart();
    t_window();
    final_report();
  end
endmodule : test_windowed_watchdog_timer
`default_nettype wire
